// >>> common/lsu_pkg.sv
// Purpose: shared constants for the lin serial address-match block
// Assumes: one 50 MHz system clock, synchronous active-high reset
// Notes:   state encodings are one-hot, written out
package lsu_pkg;
	// multiprocessor filter modes
	localparam logic [1:0] MP_OFF      = 2'h0;
	localparam logic [1:0] MP_SW       = 2'h1;
	localparam logic [1:0] MP_HW       = 2'h2;
	localparam logic [1:0] MP_HW_QUIET = 2'h3;
	// control 1 bank that holds the baud-generator control bit
	localparam logic [2:0] BANK_MPCTL  = 3'h0;
	// oversampling: sixteen ticks per bit, sample on these counts
	localparam logic [3:0] OVS_MID     = 4'h7;
	localparam logic [3:0] OVS_LAST    = 4'hF;
	// frame lengths in bits, start and stop included
	localparam logic [3:0] LEN_CHAR    = 4'hA;
	localparam logic [3:0] LEN_CHAR_MP = 4'hB;
	localparam logic [3:0] LEN_BREAK   = 4'hE;
	localparam logic [15:0] BREAK_PAT  = 16'hE000;
	localparam logic [7:0] WAKE_CHAR   = 8'h80;
	// autobaud: synch char spans 8 bits between 1st and 5th fall
	localparam logic [2:0] AB_EDGES    = 3'h5;
	localparam int         AB_SHIFT    = 7;
	localparam int         AB_W        = 24;
	localparam int         DIV_W       = 16;
	localparam logic [15:0] DIV_RST    = 16'h0000;
	// receiver and transmitter states
	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA  = 4'b0100,
		RX_STOP  = 4'b1000
	} lsu_rx_e;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_RUN  = 2'b10
	} lsu_tx_e;
endpackage : lsu_pkg

// >>> dv/lin_serial_addr_match_baud_tb_top.sv
// Purpose: self-checking bench for the filter and lin serial core
// Assumes: divisor 4, so one bit lasts 64 system clocks
// Notes:   ref_char predicts deliveries; random bytes from xorshift
`timescale 1ns/10ps
`default_nettype none
module lin_serial_addr_match_baud_tb_top;
	// divisor 4 is exact at 50 MHz, zero rate error
	localparam int DIV  = 4;
	localparam int BITC = 16 * DIV;
	logic        clk, rst, rxd, txd, echo, flip, rej, rx_en, tx_en;
	logic        lin_en, slave, sleep, bgc, perr_clr, tx_valid, tx_addr;
	logic        tx_break, tx_wake, rdy, rv, ra, irq, nf, perr, brk;
	logic        wake, abd, derr, acc, fst;
	logic [1:0]  mode;
	logic [2:0]  bank;
	logic [7:0]  cmp, tx_data, rd, cs, d;
	logic [9:0]  last;
	logic [15:0] div, meas, w;
	logic [31:0] seed = 32'h0000B61A;
	int          n_val, n_irq, n_brk, n_wake, n_abd, i0;
	int          err_total, n_tests, cyc;

	lsu_core dut (
		.i_sys_clk             (clk),
		.i_sys_rst             (rst),
		.i_multiproc_mode_sel  (mode),
		.i_addr_cmp            (cmp),
		.i_addr_reject         (rej),
		.i_rx_en               (rx_en),
		.i_tx_en               (tx_en),
		.i_lin_en              (lin_en),
		.i_lin_slave           (slave),
		.i_lin_sleep           (sleep),
		.i_baud_gen_ctrl_sel   (bgc),
		.i_ctrl1_bank_sel      (bank),
		.i_baud_divisor        (div),
		.i_phys_err_clr        (perr_clr),
		.i_tx_valid            (tx_valid),
		.i_tx_data             (tx_data),
		.i_tx_addr             (tx_addr),
		.i_tx_break            (tx_break),
		.i_tx_wake             (tx_wake),
		.o_tx_ready            (rdy),
		.o_rx_valid            (rv),
		.o_rx_data             (rd),
		.o_rx_addr             (ra),
		.o_rx_irq              (irq),
		.o_new_frame_flag      (nf),
		.o_phys_layer_err_flag (perr),
		.o_break_det           (brk),
		.o_wake_det            (wake),
		.o_autobaud_done       (abd),
		.o_baud_meas           (meas),
		.o_div_err             (derr),
		.i_rxd                 (rxd),
		.o_txd                 (txd)
	);

	lsu_bus_node node (
		.i_sys_clk (clk),
		.i_txd     (txd),
		.i_echo    (echo),
		.i_flip    (flip),
		.o_rxd     (rxd)
	);

	// 50 MHz system clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// tally one-cycle pulses; a hang ends the run, frame time-outs
	// remain a software duty sampled mid-cycle so a pulse is
	// seen settled, never in the step of the edge that launches it
	always @(negedge clk)
	begin
		cyc++;
		if (rv === 1'b1)
		begin
			n_val++;
			last = {nf, ra, rd};
		end
		if (irq === 1'b1)
			n_irq++;
		if (brk === 1'b1)
			n_brk++;
		if (wake === 1'b1)
			n_wake++;
		if (abd === 1'b1)
			n_abd++;
		if (cyc == 90000)
		begin
			err_total++;
			final_report();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// expected {delivered, new frame} for one received character
	function automatic logic [1:0] ref_char(input logic adr,
		input logic [7:0] b);
		logic hit;
		hit = (mode == lsu_pkg::MP_SW) || (b == cmp);
		if (mode == lsu_pkg::MP_OFF)
			return 2'h2;
		if (adr)
		begin
			acc = hit;
			fst = hit;
			return {hit && (mode != lsu_pkg::MP_HW_QUIET), 1'b0};
		end
		ref_char = {acc, fst & acc};
		fst = 1'b0;
	endfunction : ref_char

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// send one character and compare what the block delivered
	task automatic rx_one(input logic adr, input logic [7:0] b,
		input int bc);
		logic [1:0] e;
		int         v0;
		int         q0;
		e = ref_char(adr, b);
		v0 = n_val;
		q0 = n_irq;
		node.send({7'h00, adr, b}, (mode == lsu_pkg::MP_OFF) ? 8 : 9, bc);
		repeat (4) @(posedge clk);
		chk(16'(n_val - v0), {15'h0000, e[1]});
		chk(16'(n_irq - q0), {15'h0000, e[1]});
		if (e[1])
			chk({7'h00, last[8:0]}, {7'h00, adr, b});
		if (e[1] && !adr && mode != lsu_pkg::MP_SW)
			chk({15'h0000, last[9]}, {15'h0000, e[0]});
	endtask : rx_one

	// frames of one address byte (none in mode 0) and one to three data bytes
	task automatic mp_run(input logic [1:0] md);
		logic [7:0] a;
		int         nd;
		@(posedge clk);
		#1 mode = md;
		acc = 1'b0;
		fst = 1'b0;
		for (int f = 0; f < 4; f++)
		begin
			a = 8'(rnd());
			if (f == 1 || a[0])
				a = cmp;
			if (f == 0)
				a = cmp ^ 8'h01;
			if (md != lsu_pkg::MP_OFF)
				rx_one(1'b1, a, BITC);
			if (md == lsu_pkg::MP_SW && a != cmp)
			begin
				#1 rej = 1'b1;
				@(posedge clk);
				#1 rej = 1'b0;
				acc = 1'b0;
			end
			nd = 1 + int'(rnd() % 3);
			for (int k = 0; k < nd; k++)
				rx_one(1'b0, 8'(rnd()), BITC);
		end
		$display("filter mode %0d done", md);
	endtask : mp_run

	// hold the request over the take edge; idle means ready is high
	task automatic tx_req(input logic [7:0] b, input logic ad,
		input logic bk);
		@(posedge clk);
		#1 tx_valid = 1'b1;
		tx_data = b;
		tx_addr = ad;
		tx_break = bk;
		@(posedge clk);
		#1 tx_valid = 1'b0;
	endtask : tx_req

	// sample the pin at mid-bit from the start edge, n+2 samples
	task automatic tx_get(input int n, output logic [15:0] s);
		s = '0;
		for (int t = 0; t < 3000 && txd !== 1'b0; t++)
			@(negedge clk);
		repeat (BITC / 2) @(negedge clk);
		for (int k = 0; k <= n + 1; k++)
		begin
			s[k] = txd;
			repeat (BITC) @(negedge clk);
		end
	endtask : tx_get

	task automatic tx_chk(input logic [7:0] b, input logic ad);
		tx_req(b, ad, 1'b0);
		tx_get((mode == lsu_pkg::MP_OFF) ? 8 : 9, w);
		if (mode == lsu_pkg::MP_OFF)
			chk(w, {6'h00, 1'b1, b, 1'b0});
		else
			chk(w, {5'h00, 1'b1, ad, b, 1'b0});
	endtask : tx_chk

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	initial
	begin
		{rej, lin_en, slave, sleep, bgc, perr_clr, echo, flip} = '0;
		{tx_valid, tx_data, tx_addr, tx_break, tx_wake} = '0;
		{bank, mode, n_val, n_irq, n_brk, n_wake, n_abd} = '0;
		{err_total, n_tests, cyc} = '0;
		rst = 1'b1;
		rx_en = 1'b1;
		tx_en = 1'b1;
		div = 16'(DIV);
		cmp = 8'(rnd());
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		@(negedge clk);
		chk({13'h0000, txd, rdy, perr}, 16'h0006);
		// a request with the sender disabled must be ignored
		#1 tx_en = 1'b0;
		tx_req(8'h55, 1'b0, 1'b0);
		@(negedge clk);
		chk({14'h0000, txd, rdy}, 16'h0003);
		#1 tx_en = 1'b1;
		for (int m = 0; m < 4; m++)
			mp_run(2'(m));
		tx_chk(8'(rnd()), 1'b1);
		// reload interrupts with the receiver off, sender still usable
		@(posedge clk);
		#1 rx_en = 1'b0;
		bgc = 1'b1;
		i0 = n_irq;
		fork
			tx_chk(8'(rnd()), 1'b0);
			begin
				repeat (400) @(posedge clk);
				i0 = n_irq - i0;
				chk(16'(i0 >= 99 && i0 <= 101), 16'h0001);
			end
		join
		#1 bank = 3'h1;
		i0 = n_irq;
		repeat (200) @(posedge clk);
		chk(16'(n_irq - i0), 16'h0000);
		#1 {rx_en, bgc, bank} = 5'h10;
		$display("baud counter done");
		// slave header: break, synch at a slower rate, then response
		#1 {mode, lin_en, slave} = 4'h3;
		i0 = n_brk;
		node.send(16'h0000, 13, BITC);
		repeat (4) @(posedge clk);
		chk(16'(n_brk - i0), 16'h0001);
		node.send(16'h0055, 8, 80);
		repeat (1000) @(posedge clk);
		chk(16'(n_abd), 16'h0001);
		chk(meas, 16'h0005);
		cs = 8'h00;
		for (int k = 0; k < 4; k++)
		begin
			d = (k == 3) ? ~cs : 8'(rnd());
			cs = cs + d;
			rx_one(1'b0, d, 80);
		end
		#1 {slave, sleep} = 2'h1;
		i0 = n_wake;
		node.send(16'h0080, 8, BITC);
		chk(16'(n_wake - i0), 16'h0001);
		$display("lin receive done");
		// break sent with echo, then a corrupted echo; lin off for a
		// while drops the measured divisor, so the sender runs at DIV
		#1 {sleep, echo, lin_en} = 3'h2;
		repeat (2 * BITC) @(posedge clk);
		#1 lin_en = 1'b1;
		i0 = n_brk;
		tx_req(8'h00, 1'b0, 1'b1);
		tx_get(12, w);
		chk(w, 16'h2000);
		chk(16'(n_brk - i0), 16'h0001);
		chk({15'h0000, perr}, 16'h0000);
		// wake request overrides the data byte
		#1 tx_wake = 1'b1;
		tx_req(8'h00, 1'b0, 1'b0);
		tx_get(8, w);
		chk(w, {6'h00, 1'b1, lsu_pkg::WAKE_CHAR, 1'b0});
		#1 {tx_wake, flip} = 2'h1;
		tx_chk(8'hA5, 1'b0);
		chk({15'h0000, perr}, 16'h0001);
		#1 {flip, perr_clr} = 2'h1;
		@(posedge clk);
		#1 perr_clr = 1'b0;
		@(negedge clk);
		chk({15'h0000, perr}, 16'h0000);
		$display("lin transmit done");
		#1 div = 16'h0000;
		repeat (3) @(negedge clk);
		chk({15'h0000, derr}, 16'h0001);
		$display("divisor check done");
		final_report();
	end
endmodule : lin_serial_addr_match_baud_tb_top
`default_nettype wire

// >>> dv/lsu_bus_node.sv
// Purpose: far-side serial node that drives the block's receive pin
// Assumes: the caller gives the bit period in system clocks
// Notes:   echo loops o_txd back, flip inverts the echo
`timescale 1ns/10ps
`default_nettype none
module lsu_bus_node (
	// clock
	input  wire logic i_sys_clk,
	// loopback control
	input  wire logic i_txd,
	input  wire logic i_echo,
	input  wire logic i_flip,
	// line to the block
	output logic      o_rxd
);
	logic line;

	// bus idles high between frames, like a pulled-up line
	initial line = 1'b1;
	assign o_rxd = i_echo ? (i_txd ^ i_flip) : line;

	// start bit, n bits lsb first, then stop high
	task automatic send(input logic [15:0] b, input int n, input int bc);
		for (int k = -1; k <= n; k++)
		begin
			@(posedge i_sys_clk);
			#1 line = (k < 0) ? 1'b0 : (k == n) ? 1'b1 : b[k];
			repeat (bc - 1) @(posedge i_sys_clk);
		end
	endtask : send
endmodule : lsu_bus_node
`default_nettype wire

// >>> hdl/lsu_baud_gen.sv
// Purpose: baud reload counter, one tick per divisor clocks (16x bit)
// Assumes: divisor is static between changes; zero is invalid
// Notes:   tick doubles as the reload event
`timescale 1ns/10ps
`default_nettype none
module lsu_baud_gen #(
	parameter int DIV_W = lsu_pkg::DIV_W
) (
	// clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_sys_rst,
	// divisor
	input  wire logic [DIV_W-1:0] i_baud_divisor,
	// tick and divisor error
	output logic                  o_tick,
	output logic                  o_div_err
);
	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic             tick;
		logic             err;
	} lsu_bg_s;

	lsu_bg_s st_q;
	lsu_bg_s st_d;

	// count down, reload at zero; zero divisor parks the counter
	always_comb
	begin
		st_d      = st_q;
		st_d.tick = 1'b0;
		st_d.err  = (i_baud_divisor == '0);
		if (i_baud_divisor == '0)
			st_d.cnt = '0;
		else if (st_q.cnt == '0 || st_q.cnt >= i_baud_divisor)
		begin
			st_d.cnt  = i_baud_divisor - 1'b1;
			st_d.tick = 1'b1;
		end
		else
			st_d.cnt = st_q.cnt - 1'b1;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign o_tick    = st_q.tick;
	assign o_div_err = st_q.err;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	a_zero_div_stall: assert property (
		(i_baud_divisor == '0) |=> (o_div_err && !o_tick))
		else $error("zero divisor still ticks");
endmodule : lsu_baud_gen
`default_nettype wire

// >>> hdl/lsu_core.sv
// Purpose: async serial core with address filtering and lin services
// Assumes: i_rxd is asynchronous; control inputs are synchronous
// Notes:   no register bus; configuration and status are plain ports
//
// Overview of operation
// - Mode 10 compares address bytes with compare value, interrupts on match.
// - Mismatched address and its frame data are discarded until match.
// - Matched address interrupts, then each following data byte interrupts.
// - New-frame flag set on first data byte after match, clear later.
// - Mode 11 filters like mode 10 with no address interrupts.
// - Software scheme: after rejected address, silent until next address.
// - Lin mode: break and wake send/detect, slave autobaud measurement.
// - Lin transmit compares echoed rx with tx, sets phys error flag.
// - Checksum and identifier pass through as plain data.
// - Only the master sends headers: break, synch, identifier; the core sends a break on request even with i_lin_slave high.
// - One node sends the response: data then one checksum.
// - Baud ctrl bit in bank 000 with rx off: irq on reload.
// - Transmitter works while baud generator serves as counter.
`timescale 1ns/10ps
`default_nettype none
module lsu_core #(
	parameter int DIV_W = lsu_pkg::DIV_W
) (
	// clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_sys_rst,
	// configuration
	input  wire logic [1:0]       i_multiproc_mode_sel,
	input  wire logic [7:0]       i_addr_cmp,
	input  wire logic             i_addr_reject,
	input  wire logic             i_rx_en,
	input  wire logic             i_tx_en,
	input  wire logic             i_lin_en,
	input  wire logic             i_lin_slave,
	input  wire logic             i_lin_sleep,
	input  wire logic             i_baud_gen_ctrl_sel,
	input  wire logic [2:0]       i_ctrl1_bank_sel,
	input  wire logic [DIV_W-1:0] i_baud_divisor,
	input  wire logic             i_phys_err_clr,
	// transmit request
	input  wire logic             i_tx_valid,
	input  wire logic [7:0]       i_tx_data,
	input  wire logic             i_tx_addr,
	input  wire logic             i_tx_break,
	input  wire logic             i_tx_wake,
	output logic                  o_tx_ready,
	// receive results
	output logic                  o_rx_valid,
	output logic [7:0]            o_rx_data,
	output logic                  o_rx_addr,
	output logic                  o_rx_irq,
	output logic                  o_new_frame_flag,
	// lin status and divisor error
	output logic                  o_phys_layer_err_flag,
	output logic                  o_break_det,
	output logic                  o_wake_det,
	output logic                  o_autobaud_done,
	output logic [DIV_W-1:0]      o_baud_meas,
	output logic                  o_div_err,
	// serial pins
	input  wire logic             i_rxd,
	output logic                  o_txd
);
	typedef struct packed {
		logic                rx1;
		logic                rx2;
		logic                rx3;
		lsu_pkg::lsu_rx_e    rx_st;
		logic [3:0]          rx_ovs;
		logic [3:0]          rx_bit;
		logic [8:0]          rx_sh;
		logic                acc;
		logic                first;
		lsu_pkg::lsu_tx_e    tx_st;
		logic [3:0]          tx_ovs;
		logic [3:0]          tx_cnt;
		logic [15:0]         tx_sh;
		logic                txd;
		logic                tx_rdy;
		logic                phys_err;
		logic                rx_valid;
		logic                rx_irq;
		logic [7:0]          rx_data;
		logic                rx_addr;
		logic                nf;
		logic                brk;
		logic                wake;
		logic                ab_arm;
		logic [2:0]          ab_edges;
		logic [lsu_pkg::AB_W-1:0] ab_cnt;
		logic                ab_ok;
		logic                ab_done;
		logic [DIV_W-1:0]    ab_div;
	} lsu_core_s;

	localparam lsu_core_s RST = '{rx1: 1'b1, rx2: 1'b1, rx3: 1'b1,
		rx_st: lsu_pkg::RX_IDLE, tx_st: lsu_pkg::TX_IDLE,
		tx_sh: 16'hFFFF, txd: 1'b1, tx_rdy: 1'b1, default: '0};

	lsu_core_s        st_q;
	lsu_core_s        st_d;
	logic             tick;
	logic             div_err;
	logic [DIV_W-1:0] eff_div;
	logic             mp_on;
	logic             ch_done;
	logic             ch_abit;
	logic [7:0]       ch_data;
	logic             ch_match;
	logic             baud_irq_en;
	logic             rx_fall;
	logic             tx_take;
	logic             phys_err_hit;

	// measured divisor overrides the software one once autobaud lands
	assign eff_div    = st_q.ab_ok ? st_q.ab_div : i_baud_divisor;
	assign mp_on      = (i_multiproc_mode_sel != lsu_pkg::MP_OFF);
	// character complete at the stop bit centre
	assign ch_done    = tick && st_q.rx_st == lsu_pkg::RX_STOP
		&& st_q.rx_ovs == lsu_pkg::OVS_LAST;
	assign ch_abit    = mp_on && st_q.rx_sh[8];
	assign ch_data    = mp_on ? st_q.rx_sh[7:0] : st_q.rx_sh[8:1];
	assign ch_match   = (ch_data == i_addr_cmp);
	assign baud_irq_en = i_baud_gen_ctrl_sel && !i_rx_en
		&& i_ctrl1_bank_sel == lsu_pkg::BANK_MPCTL;
	assign rx_fall    = st_q.rx3 && !st_q.rx2;
	assign tx_take    = st_q.tx_rdy && i_tx_valid && i_tx_en;
	assign phys_err_hit = i_lin_en && tick
		&& st_q.tx_st == lsu_pkg::TX_RUN
		&& st_q.tx_ovs == lsu_pkg::OVS_MID && st_q.rx2 != st_q.txd;

	lsu_baud_gen #(
		.DIV_W(DIV_W)
	) u_baud (
		.i_sys_clk      (i_sys_clk),
		.i_sys_rst      (i_sys_rst),
		.i_baud_divisor (eff_div),
		.o_tick         (tick),
		.o_div_err      (div_err)
	);

	// next-state logic for receiver, filter, transmitter and lin extras
	always_comb
	begin
		st_d          = st_q;
		st_d.rx1      = i_rxd;
		st_d.rx2      = st_q.rx1;
		st_d.rx3      = st_q.rx2;
		st_d.rx_valid = 1'b0;
		st_d.rx_irq   = 1'b0;
		st_d.brk      = 1'b0;
		st_d.wake     = 1'b0;
		st_d.ab_done  = 1'b0;
		// receiver bit engine, centre sampling on the 16x tick
		if (!i_rx_en)
			st_d.rx_st = lsu_pkg::RX_IDLE;
		else if (tick)
		begin
			st_d.rx_ovs = st_q.rx_ovs + 4'h1;
			case (st_q.rx_st)
				lsu_pkg::RX_IDLE:
				begin
					st_d.rx_ovs = 4'h0;
					if (!st_q.rx2)
						st_d.rx_st = lsu_pkg::RX_START;
				end
				lsu_pkg::RX_START:
					if (st_q.rx_ovs == lsu_pkg::OVS_MID)
					begin
						// a glitch shorter than half a bit is rejected
						st_d.rx_st  = st_q.rx2 ? lsu_pkg::RX_IDLE
							: lsu_pkg::RX_DATA;
						st_d.rx_ovs = 4'h0;
						st_d.rx_bit = 4'h0;
					end
				lsu_pkg::RX_DATA:
					if (st_q.rx_ovs == lsu_pkg::OVS_LAST)
					begin
						st_d.rx_sh  = {st_q.rx2, st_q.rx_sh[8:1]};
						st_d.rx_bit = st_q.rx_bit + 4'h1;
						if (st_q.rx_bit == (mp_on ? 4'h8 : 4'h7))
							st_d.rx_st = lsu_pkg::RX_STOP;
					end
				lsu_pkg::RX_STOP:
					if (st_q.rx_ovs == lsu_pkg::OVS_LAST)
						st_d.rx_st = lsu_pkg::RX_IDLE;
				default:
					st_d.rx_st = lsu_pkg::RX_IDLE;
			endcase
		end
		// software scheme: reject drops the frame until next address
		if (i_addr_reject && i_multiproc_mode_sel == lsu_pkg::MP_SW)
			st_d.acc = 1'b0;
		// character delivery; id and checksum are just data here
		if (ch_done && i_lin_en && ch_data == 8'h00 && !st_q.rx2)
		begin
			st_d.brk    = 1'b1;
			st_d.ab_arm = i_lin_slave;
		end
		else if (ch_done && ch_abit)
		begin
			st_d.first = 1'b1;
			if (i_multiproc_mode_sel == lsu_pkg::MP_SW)
			begin
				st_d.acc      = 1'b1;
				st_d.rx_valid = 1'b1;
				st_d.rx_irq   = 1'b1;
			end
			else
			begin
				st_d.acc      = ch_match;
				st_d.rx_valid = ch_match
					&& i_multiproc_mode_sel == lsu_pkg::MP_HW;
				st_d.rx_irq   = st_d.rx_valid;
			end
			st_d.rx_data = ch_data;
			st_d.rx_addr = 1'b1;
			st_d.nf      = 1'b0;
		end
		else if (ch_done && (!mp_on || st_q.acc))
		begin
			st_d.rx_valid = 1'b1;
			st_d.rx_irq   = 1'b1;
			st_d.rx_data  = ch_data;
			st_d.rx_addr  = 1'b0;
			st_d.nf       = mp_on && st_q.first;
			st_d.first    = 1'b0;
		end
		// receiver off: reload ticks become receive interrupts
		if (baud_irq_en && tick)
			st_d.rx_irq = 1'b1;
		// wake-up: any dominant edge while the bus sleeps
		if (i_lin_en && i_lin_sleep && rx_fall)
			st_d.wake = 1'b1;
		// slave autobaud over the synch character after a break
		if (!i_lin_en)
		begin
			st_d.ab_ok  = 1'b0;
			st_d.ab_arm = 1'b0;
		end
		else if (st_q.ab_arm)
		begin
			if (st_q.ab_edges != 3'h0)
				st_d.ab_cnt = st_q.ab_cnt + 1'b1;
			if (rx_fall)
			begin
				st_d.ab_edges = st_q.ab_edges + 3'h1;
				// the edge cycle counts too, so the span is exact
				if (st_q.ab_edges == 3'h0)
					st_d.ab_cnt = {{(lsu_pkg::AB_W-1){1'b0}}, 1'b1};
				if (st_q.ab_edges == lsu_pkg::AB_EDGES - 3'h1)
				begin
					st_d.ab_div   = DIV_W'(st_q.ab_cnt
						>> lsu_pkg::AB_SHIFT);
					st_d.ab_ok    = 1'b1;
					st_d.ab_done  = 1'b1;
					st_d.ab_arm   = 1'b0;
					st_d.ab_edges = 3'h0;
				end
			end
		end
		// transmitter, independent of the receiver enable
		if (tx_take)
		begin
			st_d.tx_st  = lsu_pkg::TX_RUN;
			st_d.tx_rdy = 1'b0;
			st_d.tx_ovs = 4'h0;
			if (i_tx_break)
			begin
				st_d.tx_sh  = lsu_pkg::BREAK_PAT;
				st_d.tx_cnt = lsu_pkg::LEN_BREAK;
			end
			else
			begin
				st_d.tx_sh  = {5'h1F, 1'b1, !mp_on || i_tx_addr,
					i_tx_wake ? lsu_pkg::WAKE_CHAR : i_tx_data, 1'b0};
				st_d.tx_cnt = mp_on ? lsu_pkg::LEN_CHAR_MP
					: lsu_pkg::LEN_CHAR;
			end
			st_d.txd = 1'b0;
		end
		else if (st_q.tx_st == lsu_pkg::TX_RUN && tick)
		begin
			st_d.tx_ovs = st_q.tx_ovs + 4'h1;
			if (st_q.tx_ovs == lsu_pkg::OVS_LAST)
			begin
				st_d.tx_sh  = {1'b1, st_q.tx_sh[15:1]};
				st_d.txd    = st_q.tx_sh[1];
				st_d.tx_cnt = st_q.tx_cnt - 4'h1;
				if (st_q.tx_cnt == 4'h1)
				begin
					st_d.tx_st  = lsu_pkg::TX_IDLE;
					st_d.tx_rdy = 1'b1;
					st_d.txd    = 1'b1;
				end
			end
		end
		// physical-layer error is sticky; a new mismatch beats the clear
		if (phys_err_hit)
			st_d.phys_err = 1'b1;
		else if (i_phys_err_clr)
			st_d.phys_err = 1'b0;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
			st_q <= RST;
		else
			st_q <= st_d;
	end

	assign o_tx_ready            = st_q.tx_rdy;
	assign o_rx_valid            = st_q.rx_valid;
	assign o_rx_data             = st_q.rx_data;
	assign o_rx_addr             = st_q.rx_addr;
	assign o_rx_irq              = st_q.rx_irq;
	assign o_new_frame_flag      = st_q.nf;
	assign o_phys_layer_err_flag = st_q.phys_err;
	assign o_break_det           = st_q.brk;
	assign o_wake_det            = st_q.wake;
	assign o_autobaud_done       = st_q.ab_done;
	assign o_baud_meas           = st_q.ab_div;
	assign o_div_err             = div_err;
	assign o_txd                 = st_q.txd;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_addr_hit;
		ch_done && ch_abit && ch_match && !baud_irq_en
			&& i_multiproc_mode_sel == lsu_pkg::MP_HW;
	endsequence
	sequence s_brk_req;
		tx_take && i_tx_break;
	endsequence

	a_addr_match_irq: assert property (s_addr_hit |=> o_rx_irq)
		else $error("matching address gave no interrupt");
	a_nomatch_drop: assert property (
		(ch_done && ch_abit && !ch_match && i_multiproc_mode_sel[1])
		|=> (!o_rx_valid && !st_q.acc))
		else $error("mismatched address was accepted");
	a_data_irq: assert property (
		(ch_done && !ch_abit && st_q.acc && mp_on && !i_lin_en)
		|=> (o_rx_irq && o_rx_valid && !o_rx_addr))
		else $error("accepted data byte gave no interrupt");
	a_new_frame_first: assert property (
		(ch_done && !ch_abit && st_q.acc && mp_on && !i_lin_en)
		|=> (o_new_frame_flag == $past(st_q.first)))
		else $error("new-frame flag wrong on data byte");
	a_quiet_addr: assert property (
		(ch_done && ch_abit && !baud_irq_en
			&& i_multiproc_mode_sel == lsu_pkg::MP_HW_QUIET)
		|=> !o_rx_irq)
		else $error("address byte interrupted in quiet mode");
	a_sw_reject: assert property (
		(ch_done && !ch_abit && !st_q.acc && !baud_irq_en
			&& i_multiproc_mode_sel == lsu_pkg::MP_SW)
		|=> !o_rx_irq)
		else $error("rejected frame still interrupts");
	a_break_low: assert property (
		s_brk_req |=> !o_txd ##1 !o_txd)
		else $error("break did not drive the line low");
	a_phys_err_set: assert property (
		phys_err_hit |=> o_phys_layer_err_flag)
		else $error("echo mismatch missed");
	a_reload_irq: assert property (
		(baud_irq_en && tick) |=> o_rx_irq)
		else $error("reload gave no receive interrupt");
	a_tx_in_counter: assert property (
		(baud_irq_en && tx_take) |=> (!o_tx_ready && !o_txd))
		else $error("transmitter stalled in counter mode");
endmodule : lsu_core
`default_nettype wire
